/* File: pkg/dbg_access_pkg.sv */
// Purpose: Shared constants and carriers of the debug access controller
// Assumes: 32-bit AHB-Lite register bus, word aligned registers
// Notes:   Offsets are byte addresses inside the block's window
package dbg_access_pkg;

  // Register map
  localparam int unsigned OFS_W          = 4;
  localparam logic [3:0]  OFS_PIN_FUNC   = 4'h0;
  localparam logic [3:0]  OFS_TIMER_HALT = 4'h4;
  localparam logic [3:0]  OFS_STATUS     = 4'h8;
  localparam logic [3:0]  OFS_WORD_MASK  = 4'hC;

  // Pin function register fields (1 = general-purpose port)
  localparam int unsigned PF_CLK_BIT     = 0;
  localparam int unsigned PF_DATA_BIT    = 1;
  localparam logic [1:0]  PIN_FUNC_RESET = 2'h0;

  // Timer halt select fields (1 = stop while core halted)
  localparam int unsigned N_TIMERS         = 2;
  localparam int unsigned TMR_GENERAL_BIT  = 0;
  localparam int unsigned TMR_AUX_BIT      = 1;
  localparam logic [1:0]  TIMER_HALT_RESET = 2'h0;

  // Status register fields
  localparam int unsigned ST_LOCK_BIT      = 0;
  localparam int unsigned ST_CLK_GPIO_BIT  = 1;
  localparam int unsigned ST_DATA_GPIO_BIT = 2;
  localparam int unsigned ST_HALTED_BIT    = 3;
  localparam int unsigned ST_PIN_RST_BIT   = 4;
  localparam int unsigned ST_W             = 5;

  // Synchroniser lanes
  localparam int unsigned SYNC_W        = 4;
  localparam int unsigned SYNC_SWCLK    = 0;
  localparam int unsigned SYNC_SWDIO    = 1;
  localparam int unsigned SYNC_PINRST_N = 2;
  localparam int unsigned SYNC_STRAP_N  = 3;

  // AHB-Lite
  localparam int unsigned HTRANS_ACT_BIT = 1;
  localparam logic        HRESP_OKAY     = 1'b0;
  localparam logic [31:0] RDATA_RESET    = 32'h00000000;

  typedef struct packed {
    logic       valid;
    logic       wr;
    logic [3:0] ofs;
  } ahb_req_s;

  typedef struct packed {
    logic clk_rise;
    logic clk_fall;
    logic data;
  } dbg_link_s;

endpackage : dbg_access_pkg

/* File: hw/sync_two_ff.sv */
// Purpose: Two flip-flop synchroniser for asynchronous levels
// Assumes: Inputs change slowly against the system clock
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ns
`default_nettype none
module sync_two_ff #(
  parameter int unsigned W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic [W-1:0] i_async,
  output var  logic [W-1:0] o_sync
);

  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_sync;

  always_comb
  begin
    next_meta = i_async;
    next_sync = meta;
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      meta   <= '0;
      o_sync <= '0;
    end
    else
    begin
      meta   <= next_meta;
      o_sync <= next_sync;
    end
  end

endmodule : sync_two_ff
`default_nettype wire

/* File: hw/halt_freeze_ctrl.sv */
// Purpose: Run enables for watchdog and timers around debug halt
// Assumes: Halt flag comes from core logic on the same clock
// Notes:   Counters hold their value while their enable is low
`timescale 1ns/1ns
`default_nettype none
module halt_freeze_ctrl (
  input  wire logic                                 i_clk,
  input  wire logic                                 i_rst,
  input  wire logic                                 i_core_halted,
  input  wire logic [dbg_access_pkg::N_TIMERS-1:0]  i_stop_sel,
  output var  logic                                 o_watchdog_run,
  output var  logic [dbg_access_pkg::N_TIMERS-1:0]  o_timer_run
);

  logic                                next_watchdog_run;
  logic [dbg_access_pkg::N_TIMERS-1:0] next_timer_run;

  // Only the watchdog and the selected timers are gated; all other
  // peripherals get no enable from here and keep running
  always_comb
  begin
    next_watchdog_run = ~i_core_halted;
    next_timer_run    = ~({dbg_access_pkg::N_TIMERS{i_core_halted}}
                          & i_stop_sel);
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_watchdog_run <= 1'b1;
      o_timer_run    <= '1;
    end
    else
    begin
      o_watchdog_run <= next_watchdog_run;
      o_timer_run    <= next_timer_run;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  a_watchdog_stops: assert property (
    i_core_halted |=> !o_watchdog_run)
    else $error("watchdog kept running during halt");

  a_timer_select: assert property (
    i_core_halted |=> o_timer_run == ~$past(i_stop_sel))
    else $error("timer run enable ignores stop selection");

  sequence s_still_frozen;
    o_watchdog_run == 1'b0;
  endsequence

  sequence s_all_running;
    o_watchdog_run && (&o_timer_run);
  endsequence

  a_resume_run: assert property (
    $fell(i_core_halted) |-> s_still_frozen ##1 s_all_running)
    else $error("counters did not resume after halt");

endmodule : halt_freeze_ctrl
`default_nettype wire

/* File: hw/debug_access_control.sv */
// Purpose: Debug pin access control, strap lock and halt freeze
// Assumes: Pins, strap and pin reset are asynchronous to I_SYS_CLK
// Notes:   I_SYS_RST is power-on; I_WARM_RST covers other resets
//
// Register access over AHB-Lite and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module debug_access_control (
  input  wire logic                                I_SYS_CLK,
  input  wire logic                                I_SYS_RST,
  input  wire logic                                I_WARM_RST,
  input  wire logic                                I_RESET_PIN_N,
  input  wire logic                                I_DEBUG_ENABLE_STRAP_N,
  input  wire logic                                I_SWD_CLK_PIN,
  output var  logic                                O_SWD_CLK_PIN,
  output var  logic                                O_SWD_CLK_PIN_OE_N,
  input  wire logic                                I_SWD_DATA_PIN,
  output var  logic                                O_SWD_DATA_PIN,
  output var  logic                                O_SWD_DATA_PIN_OE_N,
  output var  dbg_access_pkg::dbg_link_s           O_CORE_LINK,
  input  wire logic                                I_CORE_DATA_OUT,
  input  wire logic                                I_CORE_DATA_OE,
  output var  logic [1:0]                          O_GPIO_IN,
  input  wire logic [1:0]                          I_GPIO_OUT,
  input  wire logic [1:0]                          I_GPIO_OE,
  input  wire logic                                I_CORE_HALTED,
  output var  logic                                O_WATCHDOG_RUN,
  output var  logic [dbg_access_pkg::N_TIMERS-1:0] O_TIMER_RUN,
  input  wire logic                                I_HSEL,
  input  wire logic [31:0]                         I_HADDR,
  input  wire logic [1:0]                          I_HTRANS,
  input  wire logic                                I_HWRITE,
  input  wire logic [2:0]                          I_HSIZE,
  input  wire logic [31:0]                         I_HWDATA,
  input  wire logic                                I_HREADY,
  output var  logic                                O_HREADYOUT,
  output var  logic [31:0]                         O_HRDATA,
  output var  logic                                O_HRESP
);

  function automatic logic ofs_hit(input logic [3:0] addr,
                                   input logic [3:0] ofs);
    ofs_hit = (addr & dbg_access_pkg::OFS_WORD_MASK) == ofs;
  endfunction : ofs_hit

  // Synchronised pin levels
  logic [dbg_access_pkg::SYNC_W-1:0] pin_sync;
  logic                              swclk_s;
  logic                              swdio_s;
  logic                              pin_rst_active;
  logic                              strap_n_s;

  sync_two_ff #(
    .W (dbg_access_pkg::SYNC_W)
  ) u_pin_sync (
    .i_clk   (I_SYS_CLK),
    .i_rst   (I_SYS_RST),
    .i_async ({I_DEBUG_ENABLE_STRAP_N, I_RESET_PIN_N,
               I_SWD_DATA_PIN, I_SWD_CLK_PIN}),
    .o_sync  (pin_sync)
  );

  assign swclk_s        = pin_sync[dbg_access_pkg::SYNC_SWCLK];
  assign swdio_s        = pin_sync[dbg_access_pkg::SYNC_SWDIO];
  assign pin_rst_active = ~pin_sync[dbg_access_pkg::SYNC_PINRST_N];
  assign strap_n_s      = pin_sync[dbg_access_pkg::SYNC_STRAP_N];

  // Strap lock state, cleared by power-on reset and reloaded from the strap at pin reset release
  logic pin_rst_prev;
  logic lock;
  logic pin_rst_release;
  logic next_pin_rst_prev;
  logic next_lock;

  assign pin_rst_release = pin_rst_prev & ~pin_rst_active;

  always_comb
  begin
    next_pin_rst_prev = pin_rst_active;
    next_lock         = lock;
    if (pin_rst_release)
    begin
      next_lock = ~strap_n_s;
    end
  end

  always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      pin_rst_prev <= 1'b1;
      lock         <= 1'b0;
    end
    else
    begin
      pin_rst_prev <= next_pin_rst_prev;
      lock         <= next_lock;
    end
  end

  // Register file and AHB-Lite slave
  dbg_access_pkg::ahb_req_s                req;
  dbg_access_pkg::ahb_req_s                next_req;
  logic [1:0]                              pin_func;
  logic [1:0]                              next_pin_func;
  logic [dbg_access_pkg::N_TIMERS-1:0]     timer_halt;
  logic [dbg_access_pkg::N_TIMERS-1:0]     next_timer_halt;
  logic [31:0]                             next_rdata;
  logic [dbg_access_pkg::ST_W-1:0]         status;
  logic                                    clk_gpio;
  logic                                    data_gpio;
  logic                                    addr_valid;

  assign addr_valid = I_HSEL & I_HTRANS[dbg_access_pkg::HTRANS_ACT_BIT]
                      & I_HREADY;

  // Lock overrides any port function written by software
  assign clk_gpio  = pin_func[dbg_access_pkg::PF_CLK_BIT] & ~lock;
  assign data_gpio = pin_func[dbg_access_pkg::PF_DATA_BIT] & ~lock;

  always_comb
  begin
    status = '0;
    status[dbg_access_pkg::ST_LOCK_BIT]      = lock;
    status[dbg_access_pkg::ST_CLK_GPIO_BIT]  = clk_gpio;
    status[dbg_access_pkg::ST_DATA_GPIO_BIT] = data_gpio;
    status[dbg_access_pkg::ST_HALTED_BIT]    = I_CORE_HALTED;
    status[dbg_access_pkg::ST_PIN_RST_BIT]   = pin_rst_active;
  end

  always_comb
  begin
    next_req.valid  = addr_valid;
    next_req.wr     = I_HWRITE;
    next_req.ofs    = I_HADDR[3:0];
    next_pin_func   = pin_func;
    next_timer_halt = timer_halt;
    next_rdata      = O_HRDATA;
    if (req.valid && req.wr)
    begin
      if (ofs_hit(req.ofs, dbg_access_pkg::OFS_PIN_FUNC))
      begin
        next_pin_func = I_HWDATA[1:0];
      end
      if (ofs_hit(req.ofs, dbg_access_pkg::OFS_TIMER_HALT))
      begin
        next_timer_halt = I_HWDATA[dbg_access_pkg::N_TIMERS-1:0];
      end
    end
    if (I_WARM_RST || pin_rst_active)
    begin
      next_pin_func   = dbg_access_pkg::PIN_FUNC_RESET;
      next_timer_halt = dbg_access_pkg::TIMER_HALT_RESET;
    end
    // Read data is taken from next values so a read right after a write
    // returns the new contents
    if (addr_valid && !I_HWRITE)
    begin
      next_rdata = '0;
      if (ofs_hit(I_HADDR[3:0], dbg_access_pkg::OFS_PIN_FUNC))
      begin
        next_rdata[1:0] = next_pin_func;
      end
      else if (ofs_hit(I_HADDR[3:0], dbg_access_pkg::OFS_TIMER_HALT))
      begin
        next_rdata[dbg_access_pkg::N_TIMERS-1:0] = next_timer_halt;
      end
      else if (ofs_hit(I_HADDR[3:0], dbg_access_pkg::OFS_STATUS))
      begin
        next_rdata[dbg_access_pkg::ST_W-1:0] = status;
      end
    end
  end

  always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      req        <= '0;
      pin_func   <= dbg_access_pkg::PIN_FUNC_RESET;
      timer_halt <= dbg_access_pkg::TIMER_HALT_RESET;
      O_HRDATA   <= dbg_access_pkg::RDATA_RESET;
    end
    else
    begin
      req        <= next_req;
      pin_func   <= next_pin_func;
      timer_halt <= next_timer_halt;
      O_HRDATA   <= next_rdata;
    end
  end

  assign O_HREADYOUT = 1'b1;
  assign O_HRESP     = dbg_access_pkg::HRESP_OKAY;

  // Debug link and pin drivers
  logic                      swclk_prev;
  logic                      next_swclk_prev;
  logic                      link_open;
  dbg_access_pkg::dbg_link_s next_link;
  logic                      next_clk_pin;
  logic                      next_clk_oe_n;
  logic                      next_data_pin;
  logic                      next_data_oe_n;
  logic [1:0]                next_gpio_in;

  // Link closed during pin reset or once a pin is a general port
  assign link_open = ~pin_rst_active & ~clk_gpio & ~data_gpio;

  always_comb
  begin
    next_swclk_prev    = swclk_s;
    next_link.clk_rise = link_open & swclk_s & ~swclk_prev;
    next_link.clk_fall = link_open & ~swclk_s & swclk_prev;
    next_link.data     = link_open & swdio_s;
    next_clk_pin       = 1'b0;
    next_clk_oe_n      = 1'b1;
    next_data_pin      = I_CORE_DATA_OUT;
    next_data_oe_n     = ~(I_CORE_DATA_OE & link_open);
    next_gpio_in       = 2'b00;
    if (clk_gpio)
    begin
      next_clk_pin    = I_GPIO_OUT[dbg_access_pkg::PF_CLK_BIT];
      next_clk_oe_n   = ~I_GPIO_OE[dbg_access_pkg::PF_CLK_BIT];
      next_gpio_in[dbg_access_pkg::PF_CLK_BIT] = swclk_s;
    end
    if (data_gpio)
    begin
      next_data_pin   = I_GPIO_OUT[dbg_access_pkg::PF_DATA_BIT];
      next_data_oe_n  = ~I_GPIO_OE[dbg_access_pkg::PF_DATA_BIT];
      next_gpio_in[dbg_access_pkg::PF_DATA_BIT] = swdio_s;
    end
  end

  always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      swclk_prev          <= 1'b0;
      O_CORE_LINK         <= '0;
      O_SWD_CLK_PIN       <= 1'b0;
      O_SWD_CLK_PIN_OE_N  <= 1'b1;
      O_SWD_DATA_PIN      <= 1'b0;
      O_SWD_DATA_PIN_OE_N <= 1'b1;
      O_GPIO_IN           <= 2'b00;
    end
    else
    begin
      swclk_prev          <= next_swclk_prev;
      O_CORE_LINK         <= next_link;
      O_SWD_CLK_PIN       <= next_clk_pin;
      O_SWD_CLK_PIN_OE_N  <= next_clk_oe_n;
      O_SWD_DATA_PIN      <= next_data_pin;
      O_SWD_DATA_PIN_OE_N <= next_data_oe_n;
      O_GPIO_IN           <= next_gpio_in;
    end
  end

  // Halt freeze of watchdog and timers
  halt_freeze_ctrl u_halt_freeze (
    .i_clk          (I_SYS_CLK),
    .i_rst          (I_SYS_RST),
    .i_core_halted  (I_CORE_HALTED),
    .i_stop_sel     (timer_halt),
    .o_watchdog_run (O_WATCHDOG_RUN),
    .o_timer_run    (O_TIMER_RUN)
  );

  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (I_SYS_RST);

  sequence s_status_read;
    addr_valid && !I_HWRITE
      && ofs_hit(I_HADDR[3:0], dbg_access_pkg::OFS_STATUS);
  endsequence

  sequence s_rise_seen;
    link_open && swclk_s && !swclk_prev;
  endsequence

  a_strap_latch: assert property (
    pin_rst_release |=> lock == !$past(strap_n_s))
    else $error("strap not latched at pin reset release");

  a_lock_hold: assert property (
    !pin_rst_release |=> $stable(lock))
    else $error("lock changed outside pin reset release");

  a_link_blocked: assert property (
    pin_rst_active |=> !O_CORE_LINK.clk_rise && !O_CORE_LINK.clk_fall
      && O_SWD_DATA_PIN_OE_N)
    else $error("debug traffic during pin reset");

  a_reset_debug_fn: assert property (
    (I_WARM_RST || pin_rst_active)
      |=> pin_func == dbg_access_pkg::PIN_FUNC_RESET)
    else $error("pins not back to debug function after reset");

  a_lock_keeps_link: assert property (
    (lock && !pin_rst_active) |-> link_open && !clk_gpio && !data_gpio)
    else $error("locked debug pins taken by software");

  a_gpio_takes_pin: assert property (
    (pin_func[1] && !lock) |=> O_SWD_DATA_PIN_OE_N == !$past(I_GPIO_OE[1])
      && !O_CORE_LINK.clk_rise)
    else $error("general port did not take the data pin");

  a_status_lock: assert property (
    s_status_read |=> O_HRDATA[0] == $past(lock) && O_HRDATA[31:5] == '0)
    else $error("status read does not show lock");

  a_clk_edge: assert property (
    s_rise_seen |=> O_CORE_LINK.clk_rise ##1 !O_CORE_LINK.clk_rise)
    else $error("debug clock rise not passed as one pulse");

endmodule : debug_access_control
`default_nettype wire

/* File: tb/swd_tool_model.sv */
// Purpose: Behavioural external serial debug tool driving clock and data
// Assumes: Clock stands low between frames, 400 ns period inside frames
// Notes:   Start offset keeps pin edges away from system clock edges
`timescale 1ns/1ns
`default_nettype none
module swd_tool_model (
  output var logic o_swclk,
  output var logic o_swdio,
  output var logic o_swdio_oe
);
  initial
  begin
    o_swclk    = 1'b0;
    o_swdio    = 1'b0;
    o_swdio_oe = 1'b0;
  end

  // One frame of n debug clock periods, data changes on falling edges
  task automatic frame(input int unsigned n);
    #13;
    o_swdio_oe = 1'b1;
    for (int unsigned i = 0; i < n; i++)
    begin
      #200 o_swclk = 1'b1;
      #200 o_swclk = 1'b0;
      o_swdio = ~o_swdio;
    end
    o_swdio_oe = 1'b0;
  endtask : frame
endmodule : swd_tool_model
`default_nettype wire

/* File: tb/testbench.sv */
// Purpose: Self-checking bench for the debug access controller
// Assumes: Zero-wait AHB-Lite slave, tool model on the debug pins
// Notes:   Released data line shows a changing pattern, not a held value
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic                      sys_clk = 1'b0;
  logic                      sys_rst;
  logic                      warm_rst;
  logic                      rst_pin_n;
  logic                      strap_n;
  logic                      clk_out;
  logic                      clk_oe_n;
  logic                      dio_out;
  logic                      dio_oe_n;
  logic                      dio_last = 1'b0;
  dbg_access_pkg::dbg_link_s core_link;
  logic                      core_out;
  logic                      core_oe;
  logic [1:0]                gpio_in;
  logic [1:0]                gpio_out;
  logic [1:0]                gpio_oe;
  logic                      halted;
  logic                      wdg_run;
  logic [1:0]                tmr_run;
  logic                      hsel;
  logic [31:0]               haddr;
  logic [1:0]                htrans;
  logic                      hwrite;
  logic [2:0]                hsize;
  logic [31:0]               hwdata;
  logic                      hreadyout;
  logic [31:0]               hrdata;
  logic                      hresp;
  logic                      tool_clk;
  logic                      tool_dio;
  logic                      tool_oe;
  int unsigned               rises = 0;
  int unsigned               falls = 0;
  int unsigned               cycles = 0;
  int unsigned               n_mismatch = 0;
  int unsigned               check_count = 0;

  wire logic clk_wire = clk_oe_n ? tool_clk : clk_out;
  wire logic dio_wire = !dio_oe_n ? dio_out : (tool_oe ? tool_dio : ~dio_last);

  always #25 sys_clk = ~sys_clk;

  always @(posedge sys_clk)
  begin
    dio_last <= dio_wire;
    cycles   <= cycles + 1;
    if (core_link.clk_rise === 1'b1)
      rises <= rises + 1;
    if (core_link.clk_fall === 1'b1)
      falls <= falls + 1;
    if (cycles == 5000)
    begin
      n_mismatch++;
      results();
    end
  end

  debug_access_control u_debug_access_control (
    .I_SYS_CLK(sys_clk), .I_SYS_RST(sys_rst), .I_WARM_RST(warm_rst),
    .I_RESET_PIN_N(rst_pin_n), .I_DEBUG_ENABLE_STRAP_N(strap_n),
    .I_SWD_CLK_PIN(clk_wire), .O_SWD_CLK_PIN(clk_out),
    .O_SWD_CLK_PIN_OE_N(clk_oe_n), .I_SWD_DATA_PIN(dio_wire),
    .O_SWD_DATA_PIN(dio_out), .O_SWD_DATA_PIN_OE_N(dio_oe_n),
    .O_CORE_LINK(core_link), .I_CORE_DATA_OUT(core_out),
    .I_CORE_DATA_OE(core_oe), .O_GPIO_IN(gpio_in), .I_GPIO_OUT(gpio_out),
    .I_GPIO_OE(gpio_oe), .I_CORE_HALTED(halted), .O_WATCHDOG_RUN(wdg_run),
    .O_TIMER_RUN(tmr_run), .I_HSEL(hsel), .I_HADDR(haddr),
    .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(hsize),
    .I_HWDATA(hwdata), .I_HREADY(hreadyout), .O_HREADYOUT(hreadyout),
    .O_HRDATA(hrdata), .O_HRESP(hresp)
  );

  swd_tool_model u_swd_tool_model (
    .o_swclk(tool_clk), .o_swdio(tool_dio), .o_swdio_oe(tool_oe)
  );

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : results

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic ahb(input logic wr, input logic [3:0] ofs,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge sys_clk);
    hsel   <= 1'b1;
    haddr  <= 32'(ofs);
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk("hresp", 32'(dbg_access_pkg::HRESP_OKAY), 32'(hresp));
  endtask : ahb

  task automatic wr(input logic [3:0] ofs, input logic [31:0] wd);
    logic [31:0] d;
    ahb(1'b1, ofs, wd, d);
  endtask : wr

  task automatic rd_bits(input string nm, input logic [3:0] ofs,
                         input logic [31:0] mask, input logic [31:0] e);
    logic [31:0] d;
    ahb(1'b0, ofs, 32'h00000000, d);
    chk(nm, e, d & mask);
  endtask : rd_bits

  task automatic frame_chk(input string nm, input int unsigned e);
    int unsigned r0;
    int unsigned f0;
    r0 = rises;
    f0 = falls;
    u_swd_tool_model.frame(4);
    repeat (5) @(posedge sys_clk);
    chk(nm, 32'(e), 32'(rises - r0));
    chk({nm, " falls"}, 32'(e), 32'(falls - f0));
  endtask : frame_chk

  task automatic t_reset();
    chk("clk oe_n", 32'h1, 32'(clk_oe_n));
    chk("data oe_n", 32'h1, 32'(dio_oe_n));
    rd_bits("pin func", 4'h0, 32'hFFFFFFFF, 32'h0);
    rd_bits("timer halt", 4'h4, 32'hFFFFFFFF, 32'h0);
    rd_bits("lock", 4'h8, 32'h1, 32'h0);
    rd_bits("unmapped", 4'hC, 32'hFFFFFFFF, 32'h0);
    chk("watchdog run", 32'h1, 32'(wdg_run));
  endtask : t_reset

  task automatic t_link();
    frame_chk("link rises", 4);
    core_oe  <= 1'b1;
    core_out <= 1'b1;
    repeat (2) @(posedge sys_clk);
    chk("core oe_n", 32'h0, 32'(dio_oe_n));
    chk("core data", 32'h1, 32'(dio_out));
    repeat (3) @(posedge sys_clk);
    chk("link data", 32'h1, 32'(core_link.data));
    core_oe <= 1'b0;
  endtask : t_link

  task automatic t_lock();
    rst_pin_n <= 1'b0;
    strap_n   <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rd_bits("pin reset", 4'h8, 32'h10, 32'h10);
    frame_chk("rises in reset", 0);
    rst_pin_n <= 1'b1;
    repeat (6) @(posedge sys_clk);
    strap_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rd_bits("lock set", 4'h8, 32'h1, 32'h1);
    wr(4'h0, 32'h3);
    rd_bits("locked status", 4'h8, 32'h6, 32'h0);
    rd_bits("locked func", 4'h0, 32'h3, 32'h3);
    frame_chk("locked rises", 4);
    chk("locked clk oe_n", 32'h1, 32'(clk_oe_n));
    // Tool asks for a system reset once breakpoints are set
    warm_rst <= 1'b1;
    @(posedge sys_clk);
    warm_rst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rd_bits("lock kept", 4'h8, 32'h1, 32'h1);
    rd_bits("pin func warm", 4'h0, 32'h3, 32'h0);
  endtask : t_lock

  task automatic t_gpio();
    rst_pin_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rst_pin_n <= 1'b1;
    repeat (6) @(posedge sys_clk);
    strap_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rd_bits("lock clear", 4'h8, 32'h1, 32'h0);
    wr(4'h0, 32'h3);
    rd_bits("gpio status", 4'h8, 32'h6, 32'h6);
    frame_chk("gpio rises", 0);
    gpio_oe  <= 2'h3;
    gpio_out <= 2'h1;
    repeat (2) @(posedge sys_clk);
    chk("gpio clk oe_n", 32'h0, 32'(clk_oe_n));
    chk("gpio clk", 32'h1, 32'(clk_out));
    chk("gpio data", 32'h0, 32'(dio_out));
    repeat (3) @(posedge sys_clk);
    chk("gpio in", 32'h1, 32'(gpio_in));
    gpio_oe <= 2'h0;
    strap_n <= 1'b1;
    wr(4'h0, 32'h0);
  endtask : t_gpio

  task automatic t_halt();
    for (int unsigned s = 1; s < 3; s++)
    begin
      wr(4'h4, 32'(s));
      rd_bits("halt select", 4'h4, 32'h3, 32'(s));
      halted <= 1'b1;
      repeat (2) @(posedge sys_clk);
      chk("halt watchdog", 32'h0, 32'(wdg_run));
      chk("halt timers", 32'(~s & 32'h3), 32'(tmr_run));
      rd_bits("halt status", 4'h8, 32'h8, 32'h8);
      halted <= 1'b0;
      repeat (2) @(posedge sys_clk);
      chk("resume watchdog", 32'h1, 32'(wdg_run));
      chk("resume timers", 32'h3, 32'(tmr_run));
    end
  endtask : t_halt

  initial
  begin
    sys_rst   = 1'b1;
    warm_rst  = 1'b0;
    rst_pin_n = 1'b1;
    strap_n   = 1'b1;
    core_out  = 1'b0;
    core_oe   = 1'b0;
    gpio_out  = 2'h0;
    gpio_oe   = 2'h0;
    halted    = 1'b0;
    hsel      = 1'b0;
    haddr     = 32'h00000000;
    htrans    = 2'h0;
    hwrite    = 1'b0;
    hsize     = 3'h2;
    hwdata    = 32'h00000000;
    repeat (8) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_link();
    t_lock();
    t_gpio();
    t_halt();
    results();
  end
endmodule : testbench
`default_nettype wire
